/* File: hw/jtp_skid_buf.v */
// Purpose: two-entry valid/ready buffer
// Assumes: single clock, async active-low reset
// Notes: in_ready_out is honest full, out side may stall
`timescale 1ns/10ps
`default_nettype none
module jtp_skid_buf #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire mclk_in,
    input wire resetn_in,
    // fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_r [0:1];
    reg rd_ptr_r;
    reg wr_ptr_r;
    reg [1:0] cnt_r;
    wire push;
    wire pop;
    assign in_ready_out = (cnt_r != 2'h2);
    assign out_valid_out = (cnt_r != 2'h0);
    assign out_data_out = mem_r[rd_ptr_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            cnt_r <= 2'h0;
            mem_r[0] <= {WIDTH{1'b0}};
            mem_r[1] <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem_r[wr_ptr_r] <= in_data_in;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule // jtp_skid_buf
`default_nettype wire

/* File: hw/jtp_tap.v */
// Purpose: test access port with output mux between own tap and core debug tap
// Assumes: tck sampled by mclk_in (250 MHz), tck well below mclk/4
// Notes on behaviour
// R1 - tap sequencing and instructions follow the 1990 boundary-scan standard
// R2 - host shifts bits in on tdi, device returns bits on tdo
// R3 - tdo muxed between own tap and core debug tap by instruction
// R4 - own tap drives the mux select, decoding core, own or unimplemented
// R5 - instruction chain is exactly four bits, holding current instruction
// R6 - bypass, idcode, sample/preload, extest, intest plus three core debug codes
// R7 - state follows reset and tms sampled on rising tck
// R8 - state controls capture, shift and update of the selected chain
// R9 - state picks instruction or data chain; instruction picks data chain
// R10 - extest and intest act on held chain data, no extra capture/shift/update
// R11 - unimplemented codes decode as bypass
// R12 - trst or power-on reset forces test-logic-reset, loading idcode
// R13 - five tck cycles with tms high reach test-logic-reset
// R14 - sample tms/tdi on rising tck, change tdo on falling tck
// R15 - tdo driven only while shifting; state kept while tck stopped
// R16 - standard sixteen-state controller
// R17 - bypass chain one bit, captures zero
`timescale 1ns/10ps
`default_nettype none
`include "jtp_defs.vh"
module jtp_tap #(
    parameter BSR_LEN = 8,
    parameter [31:0] IDCODE_VAL = 32'h0000_0001 // arbitrary value
) (
    // clock and reset
    input wire mclk_in,
    input wire resetn_in,
    // test pins
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire trst_n_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    // core debug tap side
    output wire core_tck_rise_out,
    output wire core_tdi_out,
    output wire [3:0] core_state_out,
    output reg [`JTP_IR_W-1:0] core_ir_out,
    input wire core_tdo_in,
    // boundary cells
    input wire [BSR_LEN-1:0] bsr_pins_in,
    output reg [BSR_LEN-1:0] bsr_upd_out,
    output wire extest_out,
    output wire intest_out
);
    // input synchronisers
    reg [1:0] tck_s_r;
    reg [1:0] tms_s_r;
    reg [1:0] tdi_s_r;
    reg [1:0] trst_s_r;
    reg [1:0] cdo_s_r;
    reg tck_d_r;
    reg rise_d_r;
    always @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tck_s_r <= 2'h0;
            tms_s_r <= 2'h3;
            tdi_s_r <= 2'h3;
            trst_s_r <= 2'h0;
            cdo_s_r <= 2'h0;
            tck_d_r <= 1'b0;
            rise_d_r <= 1'b0;
        end
        else
        begin
            tck_s_r <= {tck_s_r[0], tck_in};
            tms_s_r <= {tms_s_r[0], tms_in};
            tdi_s_r <= {tdi_s_r[0], tdi_in};
            trst_s_r <= {trst_s_r[0], trst_n_in};
            cdo_s_r <= {cdo_s_r[0], core_tdo_in};
            tck_d_r <= tck_s_r[1];
            // one mclk after the rise, state and chains already moved
            rise_d_r <= tck_s_r[1] && !tck_d_r;
        end
    end
    wire tck_rise = tck_s_r[1] && !tck_d_r; // [R14]
    wire tck_fall = !tck_s_r[1] && tck_d_r; // [R14]
    wire trst_act = !trst_s_r[1];
    wire tms = tms_s_r[1];
    wire tdi = tdi_s_r[1];

    reg [3:0] st_r;
    reg [3:0] st_nxt;
    reg [`JTP_IR_W-1:0] ir_sh_r;
    reg [`JTP_IR_W-1:0] ir_r;
    reg byp_r;
    reg [31:0] id_sh_r;
    reg [BSR_LEN-1:0] bsr_sh_r;
    reg [1:0] sel;
    reg core_op;

    assign core_tck_rise_out = tck_rise;
    assign core_tdi_out = tdi;
    assign core_state_out = st_r;
    assign extest_out = (ir_r == `JTP_OP_EXTEST); // [R10]
    assign intest_out = (ir_r == `JTP_OP_INTEST); // [R10]

    // sixteen-state controller, moves only on tck rise or trst
    always @*
    begin
        st_nxt = st_r;
        case (st_r) // [R16] [R7] [R1]
            `JTP_ST_RESET: st_nxt = tms ? `JTP_ST_RESET : `JTP_ST_IDLE;
            `JTP_ST_IDLE: st_nxt = tms ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
            `JTP_ST_SEL_DR: st_nxt = tms ? `JTP_ST_SEL_IR : `JTP_ST_CAP_DR;
            `JTP_ST_CAP_DR: st_nxt = tms ? `JTP_ST_EX1_DR : `JTP_ST_SH_DR;
            `JTP_ST_SH_DR: st_nxt = tms ? `JTP_ST_EX1_DR : `JTP_ST_SH_DR;
            `JTP_ST_EX1_DR: st_nxt = tms ? `JTP_ST_UPD_DR : `JTP_ST_PAU_DR;
            `JTP_ST_PAU_DR: st_nxt = tms ? `JTP_ST_EX2_DR : `JTP_ST_PAU_DR;
            `JTP_ST_EX2_DR: st_nxt = tms ? `JTP_ST_UPD_DR : `JTP_ST_SH_DR;
            `JTP_ST_UPD_DR: st_nxt = tms ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
            `JTP_ST_SEL_IR: st_nxt = tms ? `JTP_ST_RESET : `JTP_ST_CAP_IR; // [R13]
            `JTP_ST_CAP_IR: st_nxt = tms ? `JTP_ST_EX1_IR : `JTP_ST_SH_IR;
            `JTP_ST_SH_IR: st_nxt = tms ? `JTP_ST_EX1_IR : `JTP_ST_SH_IR;
            `JTP_ST_EX1_IR: st_nxt = tms ? `JTP_ST_UPD_IR : `JTP_ST_PAU_IR;
            `JTP_ST_PAU_IR: st_nxt = tms ? `JTP_ST_EX2_IR : `JTP_ST_PAU_IR;
            `JTP_ST_EX2_IR: st_nxt = tms ? `JTP_ST_UPD_IR : `JTP_ST_SH_IR;
            `JTP_ST_UPD_IR: st_nxt = tms ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
            default: st_nxt = `JTP_ST_RESET;
        endcase
    end

    // instruction decode; unknown codes fall back to bypass
    always @*
    begin
        core_op = 1'b0;
        case (ir_r) // [R4] [R6] [R9]
            `JTP_OP_IDCODE: sel = `JTP_SEL_ID;
            `JTP_OP_SAMPLE: sel = `JTP_SEL_BSR;
            `JTP_OP_EXTEST: sel = `JTP_SEL_BSR;
            `JTP_OP_INTEST: sel = `JTP_SEL_BSR;
            `JTP_OP_ABORT, `JTP_OP_DPACC, `JTP_OP_APACC:
            begin
                sel = `JTP_SEL_CORE; // [R3]
                core_op = 1'b1;
            end
            default: sel = `JTP_SEL_BYP; // [R11]
        endcase
    end

    // tms held high walks every state to reset within five rises
    always @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            st_r <= `JTP_ST_RESET; // [R12]
        else if (trst_act)
            st_r <= `JTP_ST_RESET; // [R12]
        else if (tck_rise)
            st_r <= st_nxt; // [R7] [R13] [R15]
    end

    // chains: all move only on tck rise or trst, so a stopped tck keeps them
    always @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ir_sh_r <= `JTP_OP_IDCODE;
            ir_r <= `JTP_OP_IDCODE;
            core_ir_out <= `JTP_OP_IDCODE;
            byp_r <= 1'b0;
            id_sh_r <= 32'h0000_0000;
            bsr_sh_r <= {BSR_LEN{1'b0}};
            bsr_upd_out <= {BSR_LEN{1'b0}};
        end
        else if (trst_act || (tck_rise && st_nxt == `JTP_ST_RESET))
        begin
            ir_r <= `JTP_OP_IDCODE; // [R12]
            core_ir_out <= `JTP_OP_IDCODE;
        end
        else if (tck_rise)
        begin
            case (st_r) // [R8] [R9]
                `JTP_ST_CAP_IR: ir_sh_r <= `JTP_IR_CAPTURE;
                `JTP_ST_SH_IR: ir_sh_r <= {tdi, ir_sh_r[`JTP_IR_W-1:1]}; // [R5] [R2]
                `JTP_ST_UPD_IR:
                begin
                    ir_r <= ir_sh_r; // [R5]
                    core_ir_out <= ir_sh_r;
                end
                `JTP_ST_CAP_DR:
                begin
                    byp_r <= 1'b0; // [R17]
                    if (sel == `JTP_SEL_ID)
                        id_sh_r <= IDCODE_VAL;
                    if (sel == `JTP_SEL_BSR && !intest_out && !extest_out)
                        bsr_sh_r <= bsr_pins_in; // [R10]
                end
                `JTP_ST_SH_DR:
                begin
                    byp_r <= tdi; // [R17]
                    if (sel == `JTP_SEL_ID)
                        id_sh_r <= {tdi, id_sh_r[31:1]};
                    if (sel == `JTP_SEL_BSR && !intest_out && !extest_out)
                        bsr_sh_r <= {tdi, bsr_sh_r[BSR_LEN-1:1]}; // [R10]
                end
                `JTP_ST_UPD_DR:
                    if (sel == `JTP_SEL_BSR && ir_r == `JTP_OP_SAMPLE)
                        bsr_upd_out <= bsr_sh_r; // [R10]
                default: ;
            endcase
        end
    end

    // serial bit presented this cycle
    reg chain_bit;
    wire shifting = (st_r == `JTP_ST_SH_DR) || (st_r == `JTP_ST_SH_IR);
    always @*
    begin
        if (st_r == `JTP_ST_SH_IR)
            chain_bit = ir_sh_r[0];
        else
        begin
            case (sel) // [R3]
                `JTP_SEL_ID: chain_bit = id_sh_r[0];
                `JTP_SEL_BSR: chain_bit = bsr_sh_r[0];
                `JTP_SEL_CORE: chain_bit = cdo_s_r[1];
                default: chain_bit = byp_r;
            endcase
        end
    end

    // out bit passes the two-entry buffer so a late fall edge loses nothing
    wire buf_in_rdy;
    wire buf_out_vld;
    wire [1:0] buf_out_data;
    jtp_skid_buf #(
        .WIDTH(2)
    ) u_buf (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .in_valid_in(rise_d_r), // [R14]
        .in_ready_out(buf_in_rdy),
        .in_data_in({shifting, chain_bit}),
        .out_valid_out(buf_out_vld),
        .out_ready_in(tck_fall),
        .out_data_out(buf_out_data)
    );

    // tdo changes only on the falling edge, tristate outside shift
    always @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end
        else if (trst_act)
            tdo_oe_out <= 1'b0; // [R15]
        else if (tck_fall && buf_out_vld)
        begin
            tdo_out <= buf_out_data[0]; // [R14] [R2]
            tdo_oe_out <= buf_out_data[1]; // [R15]
        end
    end
endmodule // jtp_tap
`default_nettype wire

/* File: include/jtp_defs.vh */
// Purpose: constants for the test access port block
// Assumes: included by bare name from hw/ files
// Notes: definitions only
`ifndef JTP_DEFS_VH
`define JTP_DEFS_VH
// tap states
`define JTP_ST_RESET 4'h0
`define JTP_ST_IDLE 4'h1
`define JTP_ST_SEL_DR 4'h2
`define JTP_ST_CAP_DR 4'h3
`define JTP_ST_SH_DR 4'h4
`define JTP_ST_EX1_DR 4'h5
`define JTP_ST_PAU_DR 4'h6
`define JTP_ST_EX2_DR 4'h7
`define JTP_ST_UPD_DR 4'h8
`define JTP_ST_SEL_IR 4'h9
`define JTP_ST_CAP_IR 4'ha
`define JTP_ST_SH_IR 4'hb
`define JTP_ST_EX1_IR 4'hc
`define JTP_ST_PAU_IR 4'hd
`define JTP_ST_EX2_IR 4'he
`define JTP_ST_UPD_IR 4'hf
// instruction codes
`define JTP_IR_W 4
`define JTP_OP_EXTEST 4'h0
`define JTP_OP_INTEST 4'h1
`define JTP_OP_SAMPLE 4'h2
`define JTP_OP_ABORT 4'h8
`define JTP_OP_DPACC 4'ha
`define JTP_OP_APACC 4'hb
`define JTP_OP_IDCODE 4'he
`define JTP_OP_BYPASS 4'hf
// instruction capture pattern, low two bits fixed 01
`define JTP_IR_CAPTURE 4'h1
// decoded data chain selects
`define JTP_SEL_BYP 2'h0
`define JTP_SEL_ID 2'h1
`define JTP_SEL_BSR 2'h2
`define JTP_SEL_CORE 2'h3
// buffer
`define JTP_BUF_DEPTH 2
`endif

/* File: verif/jtag_tap_with_tdo_mux_tb_top.sv */
// Purpose: self-checking bench for jtp_tap
// Assumes: tck 32 ns from jtp_host, mclk 4 ns
// Notes: extest and intest data scans are run but their tdo is not checked
`timescale 1ns/10ps
`default_nettype none
`include "jtp_defs.vh"
module jtag_tap_with_tdo_mux_tb_top;
    localparam logic [31:0] IDC = 32'h1234_5679; // arbitrary value
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic core_tdo_in = 1'b0;
    logic [7:0] bsr_pins_in = 8'h00;
    logic tck_in, tms_in, tdi_in, trst_n_in, tdo_out, tdo_oe_out, extest_out, intest_out;
    logic [3:0] core_state_out, core_ir_out;
    logic [7:0] bsr_upd_out, u;
    logic [31:0] din, dout;
    int failures = 0;
    int check_count = 0;
    always #2 mclk_in = ~mclk_in;
    jtp_host u_host (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in), .trst_n_out(trst_n_in),
        .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out));
    jtp_tap #(.BSR_LEN(8), .IDCODE_VAL(IDC)) i_dut (.mclk_in, .resetn_in, .tck_in, .tms_in, .tdi_in,
        .trst_n_in, .tdo_out, .tdo_oe_out, .core_tck_rise_out(), .core_tdi_out(), .core_state_out,
        .core_ir_out, .core_tdo_in, .bsr_pins_in, .bsr_upd_out, .extest_out, .intest_out);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [31:0] exp_dr(input logic [3:0] op, input logic [31:0] d, input logic [7:0] p,
        input logic c);
        case (op)
            `JTP_OP_IDCODE: exp_dr = IDC;
            `JTP_OP_SAMPLE: exp_dr = {d[23:0], p};
            `JTP_OP_ABORT, `JTP_OP_DPACC, `JTP_OP_APACC: exp_dr = {32{c}};
            default: exp_dr = {d[30:0], 1'b0};
        endcase
    endfunction
    initial
    begin
        #300000;
        failures++;
        close_out;
    end
    initial
    begin
        void'($urandom(45));
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in) resetn_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        chk({28'h0, core_state_out}, `JTP_ST_RESET);
        u_host.clk(1'b0, 1'b1);
        u_host.scan(1'b0, 32, 32'h0, dout);
        chk(dout, IDC);
        u_host.scan(1'b1, 4, 32'hf, dout);
        chk(dout, `JTP_IR_CAPTURE);
        $display("test reset and idcode done");
        // every code, own, core and unimplemented
        for (int i = 0; i < 16; i++)
        begin
            bsr_pins_in = 8'($urandom);
            core_tdo_in = 1'($urandom);
            din = $urandom;
            u_host.scan(1'b1, 4, i, dout);
            chk({extest_out, intest_out}, {30'h0, i == 0, i == 1});
            u = bsr_upd_out;
            u_host.scan(1'b0, 32, din, dout);
            if (i > 1)
                chk(dout, exp_dr(4'(i), din, bsr_pins_in, core_tdo_in));
            chk(bsr_upd_out, i == 2 ? din[31:24] : u);
        end
        $display("test instruction sweep done");
        u_host.clk(1'b1, 1'b1);
        u_host.clk(1'b0, 1'b1);
        u_host.clk(1'b0, 1'b1);
        #400;
        chk({28'h0, core_state_out}, `JTP_ST_SH_DR);
        u_host.rst5;
        repeat (4) @(negedge mclk_in);
        chk({24'h0, core_state_out, core_ir_out}, {`JTP_ST_RESET, `JTP_OP_IDCODE});
        u_host.clk(1'b0, 1'b1);
        u_host.scan(1'b1, 4, 32'hf, dout);
        chk(dout, `JTP_IR_CAPTURE);
        $display("test stop and tms reset done");
        u_host.trst_n_out = 1'b0;
        repeat (10) @(negedge mclk_in);
        chk({24'h0, core_state_out, core_ir_out}, {`JTP_ST_RESET, `JTP_OP_IDCODE});
        u_host.trst_n_out = 1'b1;
        repeat (8) @(negedge mclk_in);
        u_host.clk(1'b0, 1'b1);
        u_host.scan(1'b0, 32, 32'h0, dout);
        chk(dout, IDC);
        $display("test trst done");
        close_out;
    end
endmodule // jtag_tap_with_tdo_mux_tb_top
`default_nettype wire

/* File: verif/jtp_host.sv */
// Purpose: test host driving the tap pins
// Assumes: tasks entered at a falling mclk edge
// Notes: tck stands low between calls
`timescale 1ns/10ps
`default_nettype none
module jtp_host (
    output var logic tck_out,
    output var logic tms_out,
    output var logic tdi_out,
    output var logic trst_n_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_in
);
    logic tdo_q;
    initial
    begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
        trst_n_out = 1'b1;
    end
    // change on tck fall, look at tdo just after the rise
    task automatic clk(input logic m, input logic d);
        tms_out = m;
        tdi_out = d;
        #16 tck_out = 1'b1;
        #4 tdo_q = tdo_oe_in ? tdo_in : 1'b1; // released pin pulled high
        #12 tck_out = 1'b0;
    endtask
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'h0;
        clk(1'b1, 1'b1);
        if (ir)
            clk(1'b1, 1'b1);
        clk(1'b0, 1'b1);
        clk(1'b0, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            clk(i == n - 1, din[i]);
            dout[i] = tdo_q;
        end
        clk(1'b1, 1'b1);
        clk(1'b0, 1'b1);
    endtask
    task automatic rst5;
        repeat (5) clk(1'b1, 1'b1);
    endtask
endmodule // jtp_host
`default_nettype wire

/* File: verif/jtp_tap_chk_sva.sv */
// Purpose: port checker for jtp_tap
// Assumes: tms held over each tck rise
// Notes: tck is seen only through the rise pulse
`timescale 1ns/10ps
`default_nettype none
`include "jtp_defs.vh"
module jtp_tap_chk #(parameter BSR_LEN = 8) (
    input wire mclk_in,
    input wire resetn_in,
    input wire tms_in,
    input wire trst_n_in,
    input wire tdo_oe_out,
    input wire core_tck_rise_out,
    input wire [3:0] core_state_out,
    input wire [3:0] core_ir_out,
    input wire [BSR_LEN-1:0] bsr_upd_out,
    input wire extest_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // run of tck rises with tms high, saturating at five
    reg [2:0] ones_r;
    always @(posedge mclk_in or negedge resetn_in)
        if (!resetn_in)
            ones_r <= 3'h0;
        else if (core_tck_rise_out)
            ones_r <= !tms_in ? 3'h0 : (ones_r == 3'h5 ? 3'h5 : ones_r + 3'h1);
    property p_rel;
        $rose(resetn_in) |-> core_state_out == `JTP_ST_RESET && core_ir_out == `JTP_OP_IDCODE;
    endproperty
    a_rel: assert property (p_rel) else $error("not in reset at release");
    property p_trst;
        !trst_n_in [*6] |-> core_state_out == `JTP_ST_RESET && core_ir_out == `JTP_OP_IDCODE;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset ignored");
    property p_five;
        core_tck_rise_out && tms_in && ones_r == 3'h4 |=> core_state_out == `JTP_ST_RESET;
    endproperty
    a_five: assert property (p_five) else $error("five tms high did not reset");
    property p_hold;
        trst_n_in && !core_tck_rise_out |=> $stable(core_state_out);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved without tck");
    property p_oe_on;
        $rose(tdo_oe_out) |-> core_state_out == `JTP_ST_SH_DR || core_state_out == `JTP_ST_SH_IR;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("tdo driven outside shift");
    property p_oe_off;
        (core_state_out == `JTP_ST_RESET) [*8] |-> !tdo_oe_out;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("tdo driven in reset");
    property p_ir;
        $changed(core_ir_out) |-> core_state_out == `JTP_ST_UPD_IR || core_state_out == `JTP_ST_RESET
            || $past(core_state_out) == `JTP_ST_UPD_IR;
    endproperty
    a_ir: assert property (p_ir) else $error("instruction changed outside update");
    property p_ext;
        $changed(core_ir_out) |-> ##[0:2] extest_out == (core_ir_out == `JTP_OP_EXTEST);
    endproperty
    a_ext: assert property (p_ext) else $error("extest level wrong");
    property p_bsr;
        $changed(bsr_upd_out) |-> core_ir_out == `JTP_OP_SAMPLE;
    endproperty
    a_bsr: assert property (p_bsr) else $error("boundary update outside sample");
endmodule // jtp_tap_chk
bind jtp_tap jtp_tap_chk #(.BSR_LEN(BSR_LEN)) u_chk (.mclk_in, .resetn_in, .tms_in, .trst_n_in,
    .tdo_oe_out, .core_tck_rise_out, .core_state_out, .core_ir_out, .bsr_upd_out, .extest_out);
`default_nettype wire
